// file: rtcal_map.svh
// Register map, field positions, reset values and timing counts of the calendar clock
`ifndef RTCAL_MAP_SVH
`define RTCAL_MAP_SVH

`define RTCAL_OFS_CTRL      8'h00
`define RTCAL_OFS_FLAGS     8'h04
`define RTCAL_OFS_TIME      8'h10
`define RTCAL_OFS_DATE      8'h14
`define RTCAL_OFS_ATIME     8'h18
`define RTCAL_OFS_ADATE     8'h1C
`define RTCAL_OFS_TRIM      8'h20

`define RTCAL_CTRL_EN       15
`define RTCAL_CTRL_SRC      9
`define RTCAL_CTRL_LOCK     8
`define RTCAL_CTRL_RATE     5:4
`define RTCAL_CTRL_ALM_IE   1
`define RTCAL_CTRL_TICK_IE  0

`define RTCAL_FLAG_ALM      1
`define RTCAL_FLAG_TICK     0

`define RTCAL_F_HOUR        21:16
`define RTCAL_F_MIN         14:8
`define RTCAL_F_SEC         6:0
`define RTCAL_F_YEAR        31:24
`define RTCAL_F_MONTH       20:16
`define RTCAL_F_DAY         13:8
`define RTCAL_F_WDAY        2:0
`define RTCAL_AHOUR_EN      22
`define RTCAL_AMIN_EN       15
`define RTCAL_AMONTH_EN     21
`define RTCAL_ADAY_EN       14
`define RTCAL_AWDAY_EN      3

`define RTCAL_F_BIAS        13:12
`define RTCAL_F_BGAP        9:8
`define RTCAL_F_THR         6:4
`define RTCAL_F_DRV         1:0

`define RTCAL_MONTH_RST     5'h01
`define RTCAL_DAY_RST       6'h01
`define RTCAL_BIAS_RST      2'h3

`define RTCAL_CRYSTAL_HZ    32768
`define RTCAL_DIV_W         15
`define RTCAL_TAP_16HZ      11
`define RTCAL_TAP_32HZ      10
`define RTCAL_TAP_64HZ      9

`endif

// file: rtcal_pkg.sv
// Types shared by the calendar clock modules
package rtcal_pkg;
    typedef logic [7:0] rtcal_bcd_t;
    typedef enum logic [1:0] {
        RTCAL_RATE_1HZ  = 2'h0,
        RTCAL_RATE_16HZ = 2'h1,
        RTCAL_RATE_32HZ = 2'h2,
        RTCAL_RATE_64HZ = 2'h3
    } rtcal_rate_e;
endpackage

// file: rtcal_bcd_step.sv
// One BCD field incremented with wrap from a top value back to a bottom value
`timescale 1ns/10ps
module rtcal_bcd_step (
    input  wire rtcal_pkg::rtcal_bcd_t val,
    input  wire rtcal_pkg::rtcal_bcd_t max_v,
    input  wire rtcal_pkg::rtcal_bcd_t min_v,
    output rtcal_pkg::rtcal_bcd_t      nxt,
    output logic                       wrap
);
    // Decimal digit carry; top value restarts at bottom
    always_comb begin
        wrap = 1'b0;
        if (val >= max_v) begin
            nxt  = min_v;
            wrap = 1'b1;
        end else if (val[3:0] >= 4'h9) begin
            nxt = {val[7:4] + 4'h1, 4'h0};
        end else begin
            nxt = {val[7:4], val[3:0] + 4'h1};
        end
    end
endmodule // rtcal_bcd_step

// file: rtcal_top.sv
// Calendar clock with alarm and periodic event behind an APB slave
`timescale 1ns/10ps
`include "rtcal_map.svh"
module rtcal_top #(
    parameter int DIV_W = `RTCAL_DIV_W
) (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        crystal_tick,
    input  wire logic        internal_osc_tick,
    output logic             rtc_irq,
    output logic             crystal_select,
    output logic      [1:0]  bias_ratio,
    output logic      [1:0]  bandgap_bias,
    output logic      [2:0]  inverter_threshold,
    output logic      [1:0]  crystal_drive_current
);
    // Rate taps sit at stages 9..11, so the divider needs at least 12 bits
    if (DIV_W < 12) begin : g_bad_div
        $error("rtcal_top: DIV_W below 12 cannot serve the 16 Hz tap");
    end

    // Control fields
    logic                     en_r;
    logic                     src_r;
    logic                     lock_r;
    rtcal_pkg::rtcal_rate_e   rate_r;
    logic                     alm_ie_r;
    logic                     tick_ie_r;
    // Status flags
    logic                     tick_flag_r;
    logic                     alm_flag_r;
    // Calendar fields
    logic [6:0]               sec_r;
    logic [6:0]               min_r;
    logic [5:0]               hour_r;
    logic [5:0]               day_r;
    logic [4:0]               month_r;
    logic [7:0]               year_r;
    logic [2:0]               wday_r;
    // Alarm fields
    logic [6:0]               amin_r;
    logic [5:0]               ahour_r;
    logic [5:0]               aday_r;
    logic [4:0]               amonth_r;
    logic [2:0]               awday_r;
    logic                     amin_en_r;
    logic                     ahour_en_r;
    logic                     aday_en_r;
    logic                     amonth_en_r;
    logic                     awday_en_r;
    // Trim fields
    logic [1:0]               bias_r;
    logic [1:0]               bgap_r;
    logic [2:0]               thr_r;
    logic [1:0]               drv_r;
    // Divider and alarm history
    logic [DIV_W-1:0]         pre_r;
    logic                     match_q_r;
    // Bus answer and interrupt register
    logic [31:0]              prdata_r;
    logic                     pready_r;
    logic                     pslverr_r;
    logic                     irq_r;

    logic                     setup;
    logic                     wr_go;
    logic                     hit;
    logic                     timekeep;
    logic [31:0]              rdata;
    logic                     wr_ctrl;
    logic                     wr_flags;
    logic                     wr_time;
    logic                     wr_date;
    logic                     wr_atime;
    logic                     wr_adate;
    logic                     wr_trim;
    logic                     osc_tick;
    logic                     sec_tick;
    logic                     cal_tick;
    logic                     tick_evt;
    logic                     leap;
    logic                     match;
    logic                     alm_evt;
    logic                     tick_flag_nxt;
    logic                     alm_flag_nxt;
    rtcal_pkg::rtcal_bcd_t    dim;
    rtcal_pkg::rtcal_bcd_t    sec_nxt;
    rtcal_pkg::rtcal_bcd_t    min_nxt;
    rtcal_pkg::rtcal_bcd_t    hour_nxt;
    rtcal_pkg::rtcal_bcd_t    day_nxt;
    rtcal_pkg::rtcal_bcd_t    month_nxt;
    rtcal_pkg::rtcal_bcd_t    year_nxt;
    logic                     sec_wrap;
    logic                     min_wrap;
    logic                     hour_wrap;
    logic                     day_wrap;
    logic                     month_wrap;

    // Address decode; the lock fences only calendar and alarm words
    always_comb begin
        hit      = 1'b1;
        timekeep = 1'b0;
        unique case (paddr)
            `RTCAL_OFS_CTRL, `RTCAL_OFS_FLAGS, `RTCAL_OFS_TRIM: hit = 1'b1;
            `RTCAL_OFS_TIME, `RTCAL_OFS_DATE,
            `RTCAL_OFS_ATIME, `RTCAL_OFS_ADATE: timekeep = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    assign setup = psel & ~penable;
    // Write commits at the access edge that sees pready high
    assign wr_go = psel & penable & pready_r & pwrite & ~pslverr_r;
    assign wr_ctrl  = wr_go & (paddr == `RTCAL_OFS_CTRL);
    assign wr_flags = wr_go & (paddr == `RTCAL_OFS_FLAGS);
    assign wr_time  = wr_go & (paddr == `RTCAL_OFS_TIME);
    assign wr_date  = wr_go & (paddr == `RTCAL_OFS_DATE);
    assign wr_atime = wr_go & (paddr == `RTCAL_OFS_ATIME);
    assign wr_adate = wr_go & (paddr == `RTCAL_OFS_ADATE);
    assign wr_trim  = wr_go & (paddr == `RTCAL_OFS_TRIM);

    // Read mux, reserved bits read zero
    always_comb begin
        rdata = 32'h0000_0000;
        unique case (paddr)
            `RTCAL_OFS_CTRL: begin
                rdata[`RTCAL_CTRL_EN]      = en_r;
                rdata[`RTCAL_CTRL_SRC]     = src_r;
                rdata[`RTCAL_CTRL_LOCK]    = lock_r;
                rdata[`RTCAL_CTRL_RATE]    = rate_r;
                rdata[`RTCAL_CTRL_ALM_IE]  = alm_ie_r;
                rdata[`RTCAL_CTRL_TICK_IE] = tick_ie_r;
            end
            `RTCAL_OFS_FLAGS: begin
                rdata[`RTCAL_FLAG_ALM]  = alm_flag_r;
                rdata[`RTCAL_FLAG_TICK] = tick_flag_r;
            end
            `RTCAL_OFS_TIME: begin
                rdata[`RTCAL_F_HOUR] = hour_r;
                rdata[`RTCAL_F_MIN]  = min_r;
                rdata[`RTCAL_F_SEC]  = sec_r;
            end
            `RTCAL_OFS_DATE: begin
                rdata[`RTCAL_F_YEAR]  = year_r;
                rdata[`RTCAL_F_MONTH] = month_r;
                rdata[`RTCAL_F_DAY]   = day_r;
                rdata[`RTCAL_F_WDAY]  = wday_r;
            end
            `RTCAL_OFS_ATIME: begin
                rdata[`RTCAL_AHOUR_EN] = ahour_en_r;
                rdata[`RTCAL_F_HOUR]   = ahour_r;
                rdata[`RTCAL_AMIN_EN]  = amin_en_r;
                rdata[`RTCAL_F_MIN]    = amin_r;
            end
            `RTCAL_OFS_ADATE: begin
                rdata[`RTCAL_AMONTH_EN] = amonth_en_r;
                rdata[`RTCAL_F_MONTH]   = amonth_r;
                rdata[`RTCAL_ADAY_EN]   = aday_en_r;
                rdata[`RTCAL_F_DAY]     = aday_r;
                rdata[`RTCAL_AWDAY_EN]  = awday_en_r;
                rdata[`RTCAL_F_WDAY]    = awday_r;
            end
            `RTCAL_OFS_TRIM: begin
                rdata[`RTCAL_F_BIAS] = bias_r;
                rdata[`RTCAL_F_BGAP] = bgap_r;
                rdata[`RTCAL_F_THR]  = thr_r;
                rdata[`RTCAL_F_DRV]  = drv_r;
            end
            default: rdata = 32'h0000_0000;
        endcase
    end

    // APB answer: one wait-free access phase after every setup
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else if (ce) begin
            pready_r  <= setup;
            pslverr_r <= setup & (~hit | (timekeep & lock_r));
            if (setup & ~pwrite & hit & ~(timekeep & lock_r)) begin
                prdata_r <= rdata;
            end else begin
                prdata_r <= 32'h0000_0000;
            end
        end
    end

    // Control register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            en_r      <= 1'b0;
            src_r     <= 1'b0;
            lock_r    <= 1'b0;
            rate_r    <= rtcal_pkg::RTCAL_RATE_1HZ;
            alm_ie_r  <= 1'b0;
            tick_ie_r <= 1'b0;
        end else if (ce && wr_ctrl) begin
            en_r      <= pwdata[`RTCAL_CTRL_EN];
            src_r     <= pwdata[`RTCAL_CTRL_SRC];
            lock_r    <= pwdata[`RTCAL_CTRL_LOCK];
            rate_r    <= rtcal_pkg::rtcal_rate_e'(pwdata[`RTCAL_CTRL_RATE]);
            alm_ie_r  <= pwdata[`RTCAL_CTRL_ALM_IE];
            tick_ie_r <= pwdata[`RTCAL_CTRL_TICK_IE];
        end
    end

    assign osc_tick = src_r ? crystal_tick : internal_osc_tick;

    // one-second divider; a time write realigns the second
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pre_r <= '0;
        end else if (ce) begin
            if (wr_time) begin
                pre_r <= '0;
            end else if (en_r && osc_tick) begin
                pre_r <= pre_r + 1'b1;
            end
        end
    end

    assign sec_tick = en_r & osc_tick & (&pre_r);
    // Writes to the calendar win over the tick that lands with them
    assign cal_tick = sec_tick & ~wr_time & ~wr_date;

    // rate taps from intermediate divider stages
    always_comb begin
        unique case (rate_r)
            rtcal_pkg::RTCAL_RATE_1HZ:  tick_evt = sec_tick;
            rtcal_pkg::RTCAL_RATE_16HZ: tick_evt = &pre_r[`RTCAL_TAP_16HZ-1:0];
            rtcal_pkg::RTCAL_RATE_32HZ: tick_evt = &pre_r[`RTCAL_TAP_32HZ-1:0];
            rtcal_pkg::RTCAL_RATE_64HZ: tick_evt = &pre_r[`RTCAL_TAP_64HZ-1:0];
        endcase
        tick_evt = tick_evt & en_r & osc_tick;
    end

    // leap year: year divisible by four, 00 included
    assign leap = year_r[4] ? ((year_r[3:0] == 4'h2) | (year_r[3:0] == 4'h6))
                            : ((year_r[3:0] == 4'h0) | (year_r[3:0] == 4'h4) |
                               (year_r[3:0] == 4'h8));

    always_comb begin
        unique case (month_r)
            5'h02:                      dim = leap ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11: dim = 8'h30;
            default:                    dim = 8'h31;
        endcase
    end

    // BCD field steppers, one per carried field
    rtcal_bcd_step u_sec (
        .val   ({1'b0, sec_r}),
        .max_v (8'h59),
        .min_v (8'h00),
        .nxt   (sec_nxt),
        .wrap  (sec_wrap)
    );
    rtcal_bcd_step u_min (
        .val   ({1'b0, min_r}),
        .max_v (8'h59),
        .min_v (8'h00),
        .nxt   (min_nxt),
        .wrap  (min_wrap)
    );
    rtcal_bcd_step u_hour (
        .val   ({2'b00, hour_r}),
        .max_v (8'h23),
        .min_v (8'h00),
        .nxt   (hour_nxt),
        .wrap  (hour_wrap)
    );
    rtcal_bcd_step u_day (
        .val   ({2'b00, day_r}),
        .max_v (dim),
        .min_v (8'h01),
        .nxt   (day_nxt),
        .wrap  (day_wrap)
    );
    rtcal_bcd_step u_month (
        .val   ({3'b000, month_r}),
        .max_v (8'h12),
        .min_v (8'h01),
        .nxt   (month_nxt),
        .wrap  (month_wrap)
    );
    rtcal_bcd_step u_year (
        .val   (year_r),
        .max_v (8'h99),
        .min_v (8'h00),
        .nxt   (year_nxt),
        .wrap  ()
    );

    // Time of day: software write or one-second ripple
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sec_r  <= 7'h00;
            min_r  <= 7'h00;
            hour_r <= 6'h00;
        end else if (ce) begin
            if (wr_time) begin
                sec_r  <= pwdata[`RTCAL_F_SEC];
                min_r  <= pwdata[`RTCAL_F_MIN];
                hour_r <= pwdata[`RTCAL_F_HOUR];
            // carry ripple through the time fields
            end else if (cal_tick) begin
                sec_r <= sec_nxt[6:0];
                if (sec_wrap) begin
                    min_r <= min_nxt[6:0];
                end
                if (sec_wrap && min_wrap) begin
                    hour_r <= hour_nxt[5:0];
                end
            end
        end
    end

    // Date: software write or carry out of the hour field
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            year_r  <= 8'h00;
            month_r <= `RTCAL_MONTH_RST;
            day_r   <= `RTCAL_DAY_RST;
            wday_r  <= 3'h0;
        end else if (ce) begin
            if (wr_date) begin
                year_r  <= pwdata[`RTCAL_F_YEAR];
                month_r <= pwdata[`RTCAL_F_MONTH];
                day_r   <= pwdata[`RTCAL_F_DAY];
                wday_r  <= pwdata[`RTCAL_F_WDAY];
            // day, month, year ripple; year 99 wraps to 00
            end else if (cal_tick && sec_wrap && min_wrap && hour_wrap) begin
                day_r <= day_nxt[5:0];
                // weekday steps with the day, Saturday to Sunday
                wday_r <= (wday_r >= 3'h6) ? 3'h0 : wday_r + 3'h1;
                if (day_wrap) begin
                    month_r <= month_nxt[4:0];
                end
                if (day_wrap && month_wrap) begin
                    year_r <= year_nxt;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            amin_r      <= 7'h00;
            ahour_r     <= 6'h00;
            amin_en_r   <= 1'b0;
            ahour_en_r  <= 1'b0;
            amonth_r    <= `RTCAL_MONTH_RST;
            aday_r      <= `RTCAL_DAY_RST;
            awday_r     <= 3'h0;
            amonth_en_r <= 1'b0;
            aday_en_r   <= 1'b0;
            awday_en_r  <= 1'b0;
        end else if (ce) begin
            if (wr_atime) begin
                amin_r     <= pwdata[`RTCAL_F_MIN];
                ahour_r    <= pwdata[`RTCAL_F_HOUR];
                amin_en_r  <= pwdata[`RTCAL_AMIN_EN];
                ahour_en_r <= pwdata[`RTCAL_AHOUR_EN];
            end
            if (wr_adate) begin
                amonth_r    <= pwdata[`RTCAL_F_MONTH];
                aday_r      <= pwdata[`RTCAL_F_DAY];
                awday_r     <= pwdata[`RTCAL_F_WDAY];
                amonth_en_r <= pwdata[`RTCAL_AMONTH_EN];
                aday_en_r   <= pwdata[`RTCAL_ADAY_EN];
                awday_en_r  <= pwdata[`RTCAL_AWDAY_EN];
            end
        end
    end

    assign match = (~amin_en_r   | (amin_r   == min_r))   &
                   (~ahour_en_r  | (ahour_r  == hour_r))  &
                   (~aday_en_r   | (aday_r   == day_r))   &
                   (~amonth_en_r | (amonth_r == month_r)) &
                   (~awday_en_r  | (awday_r  == wday_r));

    // Edge of the match, so one alarm per entry into the matching time
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            match_q_r <= 1'b0;
        end else if (ce) begin
            match_q_r <= match;
        end
    end
    assign alm_evt = match & ~match_q_r;

    assign tick_flag_nxt = (tick_flag_r & ~(wr_flags & pwdata[`RTCAL_FLAG_TICK])) | tick_evt;
    assign alm_flag_nxt  = (alm_flag_r & ~(wr_flags & pwdata[`RTCAL_FLAG_ALM])) | alm_evt;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tick_flag_r <= 1'b0;
            alm_flag_r  <= 1'b0;
        end else if (ce) begin
            tick_flag_r <= tick_flag_nxt;
            alm_flag_r  <= alm_flag_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq_r <= 1'b0;
        end else if (ce) begin
            irq_r <= (tick_flag_nxt & tick_ie_r) | (alm_flag_nxt & alm_ie_r);
        end
    end

    // crystal pad trim, bias fields start at 3
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bias_r <= `RTCAL_BIAS_RST;
            bgap_r <= `RTCAL_BIAS_RST;
            thr_r  <= 3'h0;
            drv_r  <= 2'h0;
        end else if (ce && wr_trim) begin
            bias_r <= pwdata[`RTCAL_F_BIAS];
            bgap_r <= pwdata[`RTCAL_F_BGAP];
            thr_r  <= pwdata[`RTCAL_F_THR];
            drv_r  <= pwdata[`RTCAL_F_DRV];
        end
    end

    // Outputs straight from flip-flops
    assign prdata                = prdata_r;
    assign pready                = pready_r;
    assign pslverr               = pslverr_r;
    assign rtc_irq               = irq_r;
    assign crystal_select        = src_r;
    assign bias_ratio            = bias_r;
    assign bandgap_bias          = bgap_r;
    assign inverter_threshold    = thr_r;
    assign crystal_drive_current = drv_r;
endmodule // rtcal_top

// file: rtcal_chk.sv
// Port-level assertions for the calendar clock
`timescale 1ns/10ps
module rtcal_chk (
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic        ce,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        crystal_tick,
    input wire logic        internal_osc_tick,
    input wire logic        rtc_irq,
    input wire logic        crystal_select,
    input wire logic [1:0]  bias_ratio,
    input wire logic [1:0]  bandgap_bias,
    input wire logic [2:0]  inverter_threshold,
    input wire logic [1:0]  crystal_drive_current
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Setup and committed-write qualifiers
    wire setup = psel && !penable && ce;
    // A frozen clock enable commits nothing
    wire wdone = psel && penable && pready && pwrite && !pslverr && ce;
    // Zero-wait answer, only after a setup
    chk_ready_setup: assert property (setup |=> pready) else $error("no ready after setup");
    // A ready held over a frozen cycle is not a new answer
    chk_ready_cause: assert property (pready && $past(ce) |-> $past(setup))
        else $error("stray ready");
    chk_err_ready:   assert property (pslverr |-> pready) else $error("error without ready");
    chk_unmapped_err: assert property (setup && paddr == 8'h08 |=> pslverr)
        else $error("unmapped address accepted");
    // Read data is zero outside a good read
    chk_rdata_idle:  assert property (!pready || pslverr |-> prdata == 32'h0)
        else $error("read data not zero");
    chk_src_follow:  assert property (wdone && paddr == 8'h00
        |=> crystal_select == $past(pwdata[9])) else $error("source select not taken");
    chk_trim_bias:   assert property (wdone && paddr == 8'h20
        |=> bias_ratio == $past(pwdata[13:12]) && bandgap_bias == $past(pwdata[9:8]))
        else $error("bias trim not taken");
    chk_trim_drive:  assert property (wdone && paddr == 8'h20 |=> ##0
        crystal_drive_current == $past(pwdata[1:0]) && inverter_threshold == $past(pwdata[6:4]))
        else $error("drive trim not taken");
    cover property (wdone && paddr == 8'h20);
    cover property (pslverr);
    cover property ($rose(rtc_irq));
endmodule // rtcal_chk
bind rtcal_top rtcal_chk rtcal_chk_i (.core_clk(core_clk), .rstn(rstn), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .crystal_tick(crystal_tick),
    .internal_osc_tick(internal_osc_tick), .rtc_irq(rtc_irq), .crystal_select(crystal_select),
    .bias_ratio(bias_ratio), .bandgap_bias(bandgap_bias), .inverter_threshold(inverter_threshold),
    .crystal_drive_current(crystal_drive_current));

// file: testbench.sv
// Register-level testbench for the calendar clock
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
    logic        core_clk, rstn, ce, psel, penable, pwrite, crystal_tick, run, iosc;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, er, rtc_irq, crystal_select;
    logic [1:0]  bias_ratio, bandgap_bias, crystal_drive_current;
    logic [2:0]  inverter_threshold;
    int          miscompares, num_checks, n;
    // Short divider keeps a second at 4096 ticks
    rtcal_top #(.DIV_W(12)) rtcal_top_i (.core_clk(core_clk), .rstn(rstn), .ce(ce),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .crystal_tick(crystal_tick),
        .internal_osc_tick(iosc), .rtc_irq(rtc_irq), .crystal_select(crystal_select),
        .bias_ratio(bias_ratio), .bandgap_bias(bandgap_bias),
        .inverter_threshold(inverter_threshold), .crystal_drive_current(crystal_drive_current));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Crystal pulses only while a test lets time run
    always_ff @(posedge core_clk) crystal_tick <= run;
    // Internal oscillator at half rate, so a wrong source shows in the count
    always_ff @(posedge core_clk) iosc <= run & rstn & ~iosc;
    task automatic tally_and_finish;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // One APB transfer; gap cycle after so no signal is driven twice per step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge core_clk); k++; end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        if (k >= 20) begin miscompares++; tally_and_finish(); end
        psel <= 1'b0; penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("read", e, rd)
    endtask
    // Let the calendar run until the interrupt rises, bounded
    task automatic run_to_irq;
        run <= 1'b1; n = 0;
        while (rtc_irq !== 1'b1 && n < 9000) begin @(posedge core_clk); n++; end
        run <= 1'b0;
        if (n >= 9000) begin miscompares++; tally_and_finish(); end
        repeat (2) @(posedge core_clk);
    endtask
    initial begin
        rstn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; run = 1'b0; miscompares = 0; num_checks = 0;
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        `CHK("bias", 2'h3, bias_ratio)
        rdc(8'h14, 32'h0001_0100);
        rdc(8'h1C, 32'h0001_0100);
        rdc(8'h20, 32'h0000_3300);
        rdc(8'h04, 32'h0000_0002);
        apb(1'b1, 8'h04, 32'h0000_0001);
        rdc(8'h04, 32'h0000_0002);
        apb(1'b1, 8'h04, 32'h0000_0002);
        rdc(8'h04, 32'h0000_0000);
        apb(1'b0, 8'h08, 32'h0);
        `CHK("unmapped", 1'b1, er)
        $display("test reset done");
        apb(1'b1, 8'h10, 32'h0023_5959);
        apb(1'b1, 8'h14, 32'h9912_3106);
        apb(1'b1, 8'h00, 32'h0000_8201);
        run_to_irq();
        `CHK("irq", 1'b1, rtc_irq)
        rdc(8'h10, 32'h0000_0000);
        rdc(8'h14, 32'h0001_0100);
        rdc(8'h04, 32'h0000_0001);
        apb(1'b1, 8'h04, 32'h0000_0001);
        rdc(8'h04, 32'h0000_0000);
        `CHK("irq clear", 1'b0, rtc_irq)
        $display("test rollover done");
        apb(1'b1, 8'h10, 32'h0023_5959);
        apb(1'b1, 8'h14, 32'h0002_2802);
        run_to_irq();
        rdc(8'h14, 32'h0002_2903);
        apb(1'b1, 8'h04, 32'h0000_0001);
        $display("test leap done");
        // Rates 1..3 fire after a second's ticks halved 1, 2 or 3 times
        for (int r = 1; r < 4; r++) begin
            apb(1'b1, 8'h00, 32'h0000_8201 | (r << 4));
            apb(1'b1, 8'h10, 32'h0000_0000);
            run_to_irq();
            `CHK("rate", 1'b1, n >= (4096 >> r) && n <= (4096 >> r) + 5)
            `CHK("crystal", 1'b1, crystal_select)
            apb(1'b1, 8'h04, 32'h0000_0001);
        end
        $display("test rate done");
        // Minute-only alarm; tick flag recorded with its enable off
        apb(1'b1, 8'h18, 32'h0000_8100);
        rdc(8'h18, 32'h0000_8100);
        apb(1'b1, 8'h00, 32'h0000_8202);
        apb(1'b1, 8'h10, 32'h0000_0059);
        run_to_irq();
        rdc(8'h04, 32'h0000_0003);
        apb(1'b1, 8'h04, 32'h0000_0003);
        $display("test alarm done");
        apb(1'b1, 8'h00, 32'h0000_8300);
        apb(1'b0, 8'h10, 32'h0);
        `CHK("locked", 1'b1, er)
        apb(1'b1, 8'h00, 32'h0000_0200);
        apb(1'b1, 8'h10, 32'h0012_3456);
        run <= 1'b1;
        repeat (5000) @(posedge core_clk);
        run <= 1'b0;
        @(posedge core_clk);
        rdc(8'h10, 32'h0012_3456);
        // Clock enable low freezes an enabled calendar
        apb(1'b1, 8'h00, 32'h0000_8200);
        ce <= 1'b0;
        run <= 1'b1;
        repeat (5000) @(posedge core_clk);
        ce <= 1'b1;
        run <= 1'b0;
        @(posedge core_clk);
        rdc(8'h10, 32'h0012_3456);
        // Internal source: a second takes twice the crystal's cycles
        apb(1'b1, 8'h00, 32'h0000_8001);
        apb(1'b1, 8'h10, 32'h0000_0000);
        run_to_irq();
        `CHK("internal osc", 1'b1, n >= 2 * 4096 && n <= 2 * 4096 + 5)
        rdc(8'h10, 32'h0000_0001);
        apb(1'b1, 8'h20, 32'h0000_1172);
        rdc(8'h20, 32'h0000_1172);
        `CHK("drive", 2'h2, crystal_drive_current)
        `CHK("bias trim", 7'h2F, {bias_ratio, bandgap_bias, inverter_threshold})
        $display("test lock and freeze done");
        tally_and_finish();
    end
endmodule // testbench
